// ==== design/awd_pkg.sv ====
package awd_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int FT_HZ = 512;
  localparam int WD_BASE_HZ = 16;
  localparam int RST_PULSE_MIN_MS = 40;
  localparam int RST_PULSE_MAX_MS = 200;
  localparam int RST_PULSE_MS = 100;
  localparam int FT_HALF_CYC = CLK_HZ / (2 * FT_HZ);
  localparam int WD_BASE_CYC = CLK_HZ / WD_BASE_HZ;
  localparam int RST_PULSE_CYC = (CLK_HZ / 1000) * RST_PULSE_MS;

  localparam logic [12:0] OFS_FLAGS = 13'h1FF0;
  localparam logic [12:0] OFS_ALM_SEC = 13'h1FF2;
  localparam logic [12:0] OFS_ALM_MIN = 13'h1FF3;
  localparam logic [12:0] OFS_ALM_HOUR = 13'h1FF4;
  localparam logic [12:0] OFS_ALM_DATE = 13'h1FF5;
  localparam logic [12:0] OFS_ENABLES = 13'h1FF6;
  localparam logic [12:0] OFS_TIMEOUT = 13'h1FF7;
  localparam logic [12:0] OFS_DAY = 13'h1FFC;

  localparam int FLG_TIMEOUT = 7;
  localparam int FLG_ALARM = 6;
  localparam int EN_IRQ = 7;
  localparam int EN_BACKUP = 5;
  localparam int WD_STEER = 7;
  localparam int WD_MUL_HI = 6;
  localparam int WD_MUL_LO = 2;
  localparam int WD_RES_HI = 1;
  localparam int DAY_FT = 6;
  localparam int ALM_MASK = 7;

  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_ALARM = 8'h00;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [12:0] addr;
    logic [7:0] dq;
  } awd_bus_t;

  typedef struct packed {
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } awd_time_t;
endpackage

// ==== design/awd_sync.sv ====
`timescale 1ns/1ps
module awd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== design/awd_top.sv ====
`timescale 1ns/1ps
module awd_top #(
  parameter int FT_HALF_CYC = awd_pkg::FT_HALF_CYC,
  parameter int WD_BASE_CYC = awd_pkg::WD_BASE_CYC,
  parameter int RST_PULSE_CYC = awd_pkg::RST_PULSE_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic [12:0] ADDR,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire awd_pkg::awd_time_t TIME_NOW,
  input wire logic SEC_TICK,
  input wire logic OSC_RUN,
  input wire logic ON_BATTERY,
  input wire logic POWER_UP,
  output logic IRQ_OR_TEST_OUT_N_OUT,
  output logic IRQ_OR_TEST_OUT_N_OE_N,
  output logic RST_OUT,
  output logic RST_OE_N,
  output logic FREQ_TEST_SELECT
);
  localparam int FTW = $clog2(FT_HALF_CYC + 1);
  localparam int BW = $clog2(WD_BASE_CYC + 1);
  localparam int RW = $clog2(RST_PULSE_CYC + 1);

  if (FT_HALF_CYC < 1 || WD_BASE_CYC < 1 || RST_PULSE_CYC < 1) begin : g_chk
    $error("timing counts must be at least one cycle");
  end

  // reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // bus pins pass two flops
  awd_pkg::awd_bus_t bus_pin;
  awd_pkg::awd_bus_t bus_s;

  assign bus_pin = '{ce_n: CE_N, oe_n: OE_N, we_n: WE_N, addr: ADDR, dq: DQ_IN};

  awd_sync #(.W($bits(awd_pkg::awd_bus_t))) u_bus_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .d(bus_pin),
    .q(bus_s)
  );

  logic active;
  logic active_r;
  logic acc_start;
  logic acc_end;
  logic acc_wr_r;
  logic [12:0] acc_addr_r;
  logic [7:0] acc_dq_r;

  assign active = !bus_s.ce_n && (!bus_s.oe_n || !bus_s.we_n);
  assign acc_start = active && !active_r;
  assign acc_end = !active && active_r;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      acc_wr_r <= 1'b0;
      acc_addr_r <= 13'h0000;
      acc_dq_r <= 8'h00;
    end else begin
      active_r <= active;
      if (active) begin
        acc_wr_r <= !bus_s.we_n;
        acc_addr_r <= bus_s.addr;
        acc_dq_r <= bus_s.dq;
      end
    end
  end

  logic wr_commit;
  logic flags_start;
  logic flags_end;
  logic wd_touch;

  assign wr_commit = acc_end && acc_wr_r;
  assign flags_start = acc_start && bus_s.addr == awd_pkg::OFS_FLAGS;
  assign flags_end = acc_end && acc_addr_r == awd_pkg::OFS_FLAGS;
  assign wd_touch = acc_end && acc_addr_r == awd_pkg::OFS_TIMEOUT;

  // registers
  logic [7:0] alm_r [4];
  logic [7:0] enables_r;
  logic [7:0] timeout_r;
  logic ft_r;
  logic af_r;
  logic wf_r;
  logic alarm_irq_r;
  logic wd_irq_r;
  logic rst_busy_r;
  logic rst_done;
  logic expire;
  logic alarm_hit;
  logic alarm_fire;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        alm_r[i] <= awd_pkg::RST_ALARM;
      end
    end else if (wr_commit && acc_addr_r >= awd_pkg::OFS_ALM_SEC && acc_addr_r <= awd_pkg::OFS_ALM_DATE) begin
      alm_r[2'(acc_addr_r - awd_pkg::OFS_ALM_SEC)] <= acc_dq_r;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      enables_r <= awd_pkg::RST_ENABLES;
    end else if (POWER_UP) begin
      enables_r[awd_pkg::EN_IRQ] <= 1'b0;
      enables_r[awd_pkg::EN_BACKUP] <= 1'b0;
    end else if (wr_commit && acc_addr_r == awd_pkg::OFS_ENABLES) begin
      enables_r <= acc_dq_r;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      timeout_r <= awd_pkg::RST_TIMEOUT;
    end else if (wr_commit && acc_addr_r == awd_pkg::OFS_TIMEOUT) begin
      timeout_r <= acc_dq_r;
    end else if (rst_done) begin
      timeout_r <= 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ft_r <= 1'b0;
    end else if (wr_commit && acc_addr_r == awd_pkg::OFS_DAY) begin
      ft_r <= acc_dq_r[awd_pkg::DAY_FT];
    end else if (rst_done) begin
      ft_r <= 1'b0;
    end
  end

  assign FREQ_TEST_SELECT = ft_r;

  // alarm matcher
  logic ae;
  logic abe;
  logic [3:0] mask;

  assign ae = enables_r[awd_pkg::EN_IRQ];
  assign abe = enables_r[awd_pkg::EN_BACKUP];
  assign mask = {alm_r[3][awd_pkg::ALM_MASK], alm_r[2][awd_pkg::ALM_MASK],
                 alm_r[1][awd_pkg::ALM_MASK], alm_r[0][awd_pkg::ALM_MASK]};

  always_comb begin
    logic s_eq;
    logic m_eq;
    logic h_eq;
    logic d_eq;
    s_eq = alm_r[0][6:0] == TIME_NOW.sec[6:0];
    m_eq = alm_r[1][6:0] == TIME_NOW.min[6:0];
    h_eq = alm_r[2][5:0] == TIME_NOW.hour[5:0];
    d_eq = alm_r[3][5:0] == TIME_NOW.date[5:0];
    case (mask)
      4'hF: alarm_hit = 1'b1;
      4'hE: alarm_hit = s_eq;
      4'hC: alarm_hit = s_eq && m_eq;
      4'h8: alarm_hit = s_eq && m_eq && h_eq;
      4'h0: alarm_hit = s_eq && m_eq && h_eq && d_eq;
      default: alarm_hit = 1'b1;
    endcase
  end

  assign alarm_fire = SEC_TICK && alarm_hit;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      af_r <= 1'b0;
    end else if (alarm_fire) begin
      af_r <= 1'b1;
    end else if (flags_end) begin
      af_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      alarm_irq_r <= 1'b0;
    end else if (alarm_fire && ae && (!ON_BATTERY || abe)) begin
      alarm_irq_r <= 1'b1;
    end else if (flags_start) begin
      alarm_irq_r <= 1'b0;
    end
  end

  // watchdog
  logic [BW-1:0] base_cnt_r;
  logic base_tick;
  logic [10:0] wd_cnt_r;
  logic [10:0] period;
  logic wd_steer;

  assign wd_steer = timeout_r[awd_pkg::WD_STEER];
  assign period = 11'({6'h00, timeout_r[awd_pkg::WD_MUL_HI:awd_pkg::WD_MUL_LO]})
                  << {timeout_r[awd_pkg::WD_RES_HI:0], 1'b0};
  assign base_tick = base_cnt_r == BW'(WD_BASE_CYC - 1);
  assign expire = base_tick && timeout_r != 8'h00 && period != 11'h000
                  && wd_cnt_r + 11'h001 >= period && !wd_touch;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_r <= '0;
    end else if (wd_touch || base_tick) begin
      base_cnt_r <= '0;
    end else begin
      base_cnt_r <= base_cnt_r + BW'(1);
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_r <= 11'h000;
    end else if (wd_touch || expire) begin
      wd_cnt_r <= 11'h000;
    end else if (base_tick) begin
      wd_cnt_r <= wd_cnt_r + 11'h001;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wf_r <= 1'b0;
    end else if (expire) begin
      wf_r <= 1'b1;
    end else if (flags_end) begin
      wf_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_irq_r <= 1'b0;
    end else if (expire && !wd_steer) begin
      wd_irq_r <= 1'b1;
    end else if (flags_start || (acc_start && bus_s.addr == awd_pkg::OFS_TIMEOUT)) begin
      wd_irq_r <= 1'b0;
    end
  end

  // reset pulse
  logic [RW-1:0] rst_cnt_r;

  assign rst_done = rst_busy_r && rst_cnt_r == RW'(RST_PULSE_CYC - 1);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rst_busy_r <= 1'b0;
      rst_cnt_r <= '0;
    end else if (expire && wd_steer && !rst_busy_r) begin
      rst_busy_r <= 1'b1;
      rst_cnt_r <= '0;
    end else if (rst_done) begin
      rst_busy_r <= 1'b0;
      rst_cnt_r <= '0;
    end else if (rst_busy_r) begin
      rst_cnt_r <= rst_cnt_r + RW'(1);
    end
  end

  assign RST_OUT = 1'b0;
  assign RST_OE_N = !rst_busy_r;

  // frequency test toggle
  logic [FTW-1:0] ft_cnt_r;
  logic ft_phase_r;
  logic ft_cond;
  logic irq_low;
  logic drive_low_r;

  assign ft_cond = OSC_RUN && ft_r && !ae && (wd_steer || timeout_r == 8'h00);
  assign irq_low = alarm_irq_r || (wd_irq_r && !wd_steer);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ft_cnt_r <= '0;
      ft_phase_r <= 1'b0;
    end else if (!OSC_RUN) begin
      ft_cnt_r <= '0;
    end else if (ft_cnt_r == FTW'(FT_HALF_CYC - 1)) begin
      ft_cnt_r <= '0;
      ft_phase_r <= !ft_phase_r;
    end else begin
      ft_cnt_r <= ft_cnt_r + FTW'(1);
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      drive_low_r <= 1'b0;
    end else begin
      drive_low_r <= irq_low || (ft_cond && ft_phase_r);
    end
  end

  assign IRQ_OR_TEST_OUT_N_OUT = 1'b0;
  assign IRQ_OR_TEST_OUT_N_OE_N = !drive_low_r;

  // read path
  logic [7:0] rd_data;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 8'h00;
    case (bus_s.addr)
      awd_pkg::OFS_FLAGS: begin
        rd_data[awd_pkg::FLG_TIMEOUT] = wf_r;
        rd_data[awd_pkg::FLG_ALARM] = af_r;
      end
      awd_pkg::OFS_ALM_SEC: rd_data = alm_r[0];
      awd_pkg::OFS_ALM_MIN: rd_data = alm_r[1];
      awd_pkg::OFS_ALM_HOUR: rd_data = alm_r[2];
      awd_pkg::OFS_ALM_DATE: rd_data = alm_r[3];
      awd_pkg::OFS_ENABLES: rd_data = enables_r;
      awd_pkg::OFS_TIMEOUT: rd_data = timeout_r;
      default: rd_hit = 1'b0;
    endcase
  end

  logic dq_drive_r;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DQ_OUT <= 8'h00;
      dq_drive_r <= 1'b0;
    end else begin
      DQ_OUT <= rd_data;
      dq_drive_r <= !bus_s.ce_n && !bus_s.oe_n && bus_s.we_n && rd_hit;
    end
  end

  assign DQ_OE_N = !dq_drive_r;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  sequence flags_open;
    flags_start && !alarm_fire;
  endsequence

  sequence flags_close;
    flags_end && !alarm_fire;
  endsequence

  ft_toggle_a: assert property (
    OSC_RUN && ft_cnt_r == FTW'(FT_HALF_CYC - 1) |=> ft_phase_r != $past(ft_phase_r)
  ) else $error("test toggle missed its half period");

  open_drain_a: assert property (
    IRQ_OR_TEST_OUT_N_OUT == 1'b0 && RST_OUT == 1'b0
  ) else $error("open drain output driven high");

  alarm_flag_a: assert property (
    alarm_fire |=> af_r
  ) else $error("alarm match did not set flag");

  alarm_gate_a: assert property (
    $rose(alarm_irq_r) |-> $past(ae && (!ON_BATTERY || abe))
  ) else $error("alarm irq raised without its enables");

  irq_release_a: assert property (
    flags_open ##1 (active && !alarm_fire) |=> !alarm_irq_r
  ) else $error("alarm irq held during flags access");

  release_order_a: assert property (
    flags_open |=> !alarm_irq_r ##0 (af_r || !$past(af_r))
  ) else $error("alarm flag cleared before irq release");

  wd_restart_a: assert property (
    wd_touch |=> wd_cnt_r == 11'h000 && base_cnt_r == '0
  ) else $error("watchdog access did not restart period");

  wd_disabled_a: assert property (
    timeout_r == 8'h00 |=> !$rose(wf_r) && !$rose(wd_irq_r) && !$fell(RST_OE_N)
  ) else $error("disabled watchdog expired");

  pulse_len_a: assert property (
    $rose(RST_OE_N) |-> $past(rst_cnt_r) == RW'(RST_PULSE_CYC - 1)
  ) else $error("reset pulse length wrong");

  pulse_clear_a: assert property (
    rst_done && !wr_commit |=> timeout_r == 8'h00 && !ft_r
  ) else $error("pulse end did not clear watchdog");

  steer_irq_a: assert property (
    expire && !wd_steer |=> wd_irq_r ##1 !IRQ_OR_TEST_OUT_N_OE_N
  ) else $error("watchdog expiry not on shared output");

  ft_denied_a: assert property (
    !wd_steer && timeout_r != 8'h00 && !irq_low |=> IRQ_OR_TEST_OUT_N_OE_N
  ) else $error("test toggle not denied by watchdog");
endmodule

// ==== testbench/alarm_watchdog_irq_logic_bench.sv ====
`timescale 1ns/1ps
module alarm_watchdog_irq_logic_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce_n, oe_n, we_n, dq_oe_n, irq_oe_n, rst_oe_n, ft_sel;
  logic irq_out, rst_out;
  logic [12:0] addr;
  logic [7:0] dq_in, dq_out;
  awd_pkg::awd_time_t now = 32'h0000_0000;
  logic tick = 1'b0;
  logic osc = 1'b0;
  logic bat = 1'b0;
  logic pwr = 1'b0;
  int bad_count = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  awd_host u_host (.clk(clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_in(dq_in));

  awd_top #(.FT_HALF_CYC(4), .WD_BASE_CYC(8), .RST_PULSE_CYC(5)) u_dut (.CLK(clk), .RESET_N(rst_n),
    .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE_N(dq_oe_n), .TIME_NOW(now), .SEC_TICK(tick), .OSC_RUN(osc), .ON_BATTERY(bat),
    .POWER_UP(pwr), .IRQ_OR_TEST_OUT_N_OUT(irq_out), .IRQ_OR_TEST_OUT_N_OE_N(irq_oe_n), .RST_OUT(rst_out), .RST_OE_N(rst_oe_n),
    .FREQ_TEST_SELECT(ft_sel));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("wrong value at time %0h: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic v;
    u_host.acc(1'b1, a, d, r, v);
  endtask

  task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic v;
    u_host.acc(1'b0, a, 8'h00, r, v);
    chk(v, 1'b1);
    chk(r, exp);
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  task automatic pulse_tick();
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // waits for the irq pin (0) or the reset pin (1) to go low
  task automatic wait_low(input logic which, output int n);
    for (n = 0; n < 2000 && (which ? rst_oe_n : irq_oe_n) !== 1'b0; n++) begin
      @(negedge clk);
    end
    if (n == 2000) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic test_reset();
    logic [7:0] r;
    logic v;
    chk(ft_sel, 1'b0);
    chk({irq_oe_n, rst_oe_n}, 2'b11);
    chk({irq_out, rst_out}, 2'b00);
    rdchk(awd_pkg::OFS_TIMEOUT, 8'h00);
    rdchk(awd_pkg::OFS_ENABLES, 8'h00);
    rdchk(awd_pkg::OFS_FLAGS, 8'h00);
    u_host.acc(1'b0, 13'h1FF1, 8'h00, r, v);
    chk(v, 1'b0);
    wr(awd_pkg::OFS_ENABLES, 8'hA0);
    rdchk(awd_pkg::OFS_ENABLES, 8'hA0);
    wr(awd_pkg::OFS_ENABLES, 8'h00);
    $display("test reset done");
  endtask

  task automatic alarm_try(input logic [3:0] m, input logic [31:0] tm, input logic exp);
    wr(awd_pkg::OFS_ALM_SEC, {m[0], 7'h11});
    wr(awd_pkg::OFS_ALM_MIN, {m[1], 7'h22});
    wr(awd_pkg::OFS_ALM_HOUR, {m[2], 7'h03});
    wr(awd_pkg::OFS_ALM_DATE, {m[3], 7'h04});
    now = tm;
    pulse_tick();
    rdchk(awd_pkg::OFS_FLAGS, {1'b0, exp, 6'h00});
  endtask

  task automatic test_alarm_modes();
    for (int m = 0; m < 16; m++) begin
      alarm_try(m[3:0], 32'h05042312, !(m inside {4'hE, 4'hC, 4'h8, 4'h0}));
    end
    alarm_try(4'hE, 32'h05042311, 1'b1);
    alarm_try(4'hC, 32'h05042211, 1'b1);
    alarm_try(4'h8, 32'h05042211, 1'b0);
    alarm_try(4'h8, 32'h05032211, 1'b1);
    alarm_try(4'h0, 32'h05032211, 1'b0);
    alarm_try(4'h0, 32'h04032211, 1'b1);
    $display("test alarm modes done");
  endtask

  task automatic test_alarm_irq();
    alarm_try(4'hF, 32'h05042312, 1'b1);
    wr(awd_pkg::OFS_ENABLES, 8'h80);
    pulse_tick();
    chk(irq_oe_n, 1'b0);
    rdchk(awd_pkg::OFS_FLAGS, 8'h40);
    chk(irq_oe_n, 1'b1);
    rdchk(awd_pkg::OFS_FLAGS, 8'h00);
    bat = 1'b1;
    pulse_tick();
    chk(irq_oe_n, 1'b1);
    rdchk(awd_pkg::OFS_FLAGS, 8'h40);
    wr(awd_pkg::OFS_ENABLES, 8'hA0);
    pulse_tick();
    chk(irq_oe_n, 1'b0);
    wr(awd_pkg::OFS_FLAGS, 8'h00);
    chk(irq_oe_n, 1'b1);
    bat = 1'b0;
    pwr = 1'b1;
    pulse_tick();
    rdchk(awd_pkg::OFS_ENABLES, 8'h00);
    rdchk(awd_pkg::OFS_FLAGS, 8'h40);
    pwr = 1'b0;
    $display("test alarm irq done");
  endtask

  task automatic test_watchdog();
    int n;
    for (int r = 0; r < 4; r++) begin
      wr(awd_pkg::OFS_TIMEOUT, {1'b0, 5'd3, r[1:0]});
      wait_low(1'b0, n);
      chk(n + 8 > (24 << (2 * r)) && n <= (24 << (2 * r)) + 4, 1'b1);
      wr(awd_pkg::OFS_TIMEOUT, 8'h00);
      chk(irq_oe_n, 1'b1);
      rdchk(awd_pkg::OFS_FLAGS, 8'h80);
      rdchk(awd_pkg::OFS_FLAGS, 8'h00);
    end
    wr(awd_pkg::OFS_TIMEOUT, 8'h0D);
    repeat (4) begin
      repeat (60) @(negedge clk);
      rdchk(awd_pkg::OFS_TIMEOUT, 8'h0D);
      chk(irq_oe_n, 1'b1);
    end
    wait_low(1'b0, n);
    rdchk(awd_pkg::OFS_TIMEOUT, 8'h0D);
    chk(irq_oe_n, 1'b1);
    wr(awd_pkg::OFS_TIMEOUT, 8'h00);
    rdchk(awd_pkg::OFS_FLAGS, 8'h80);
    repeat (600) @(negedge clk);
    chk(irq_oe_n, 1'b1);
    rdchk(awd_pkg::OFS_FLAGS, 8'h00);
    wr(awd_pkg::OFS_DAY, 8'h40);
    chk(ft_sel, 1'b1);
    wr(awd_pkg::OFS_TIMEOUT, 8'h8C);
    wait_low(1'b1, n);
    for (n = 0; n < 300 && rst_oe_n === 1'b0; n++) begin
      @(negedge clk);
      chk(irq_oe_n, 1'b1);
      chk(rst_out, 1'b0);
    end
    chk(n, 5);
    repeat (3) @(negedge clk);
    chk(ft_sel, 1'b0);
    rdchk(awd_pkg::OFS_TIMEOUT, 8'h00);
    rdchk(awd_pkg::OFS_FLAGS, 8'h80);
    $display("test watchdog done");
  endtask

  task automatic ft_try(input logic exp);
    int n;
    logic p;
    n = 0;
    p = irq_oe_n;
    repeat (40) begin
      @(negedge clk);
      if (irq_oe_n !== p) n++;
      p = irq_oe_n;
    end
    chk(n, exp ? 10 : 0);
  endtask

  task automatic test_freq();
    osc = 1'b1;
    wr(awd_pkg::OFS_DAY, 8'h40);
    ft_try(1'b1);
    wr(awd_pkg::OFS_TIMEOUT, 8'hFF);
    ft_try(1'b1);
    wr(awd_pkg::OFS_TIMEOUT, 8'h7F);
    ft_try(1'b0);
    wr(awd_pkg::OFS_TIMEOUT, 8'h00);
    wr(awd_pkg::OFS_ENABLES, 8'h80);
    ft_try(1'b0);
    wr(awd_pkg::OFS_ENABLES, 8'h00);
    osc = 1'b0;
    // let the last toggle phase drain before counting edges
    repeat (2) @(negedge clk);
    ft_try(1'b0);
    wr(awd_pkg::OFS_TIMEOUT, 8'h7F);
    do_reset();
    chk(ft_sel, 1'b0);
    rdchk(awd_pkg::OFS_TIMEOUT, 8'h00);
    $display("test freq and reset done");
  endtask

  initial begin
    do_reset();
    test_reset();
    test_alarm_modes();
    test_alarm_irq();
    test_watchdog();
    test_freq();
    conclude();
  end
endmodule

// ==== testbench/awd_host.sv ====
`timescale 1ns/1ps
module awd_host (
  input wire logic clk,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [12:0] addr,
  output logic [7:0] dq_in
);
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 13'h0000;
    dq_in = 8'h00;
  end

  // one byte cycle; a flags access services both irqs, a timeout register access only the watchdog irq
  task automatic acc(input logic wr, input logic [12:0] a, input logic [7:0] wd,
                     output logic [7:0] rd, output logic drv);
    @(negedge clk);
    addr = a;
    dq_in = wd;
    ce_n = 1'b0;
    oe_n = wr;
    we_n = !wr;
    repeat (6) @(negedge clk);
    rd = dq_out;
    drv = !dq_oe_n;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    // released lines do not keep the old value
    addr = ~a;
    dq_in = ~wd;
    repeat (4) @(negedge clk);
  endtask
endmodule
